/* ser_status_top.sv */
// Status event reporting: condition, event and enable registers per group
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Operation condition query returns live operating state, never latched.
// - Operation bits: 14,12,11,10,9,8,6,5 used; 15,13,7,4..0 unused.
// - Operation summary, status byte bit 7, ORs enabled operation events.
// - Operation enable query returns the mask currently held.
// - Operation event register is read-only and latches every rising edge of a used bit.
// - Reading operation events returns them and clears all bits except those rising in that cycle.
// - Preset loads operation mask with 8193 and questionable mask with 255.
// - Only questionable bits 13 and 12 latch; register is read-only.
// - Questionable mode error bits 0 and 1 never latch.
// - Reading questionable events returns them and clears latched bits.
// - Questionable bits: 14,13,12,6,3,1,0 used; others unused.
// - Questionable condition query returns live state, never latched.
// - Questionable bits 1 and 0 may be set together while settling.
// - A one bit means active or enabled; zero means inactive.
// - Questionable summary, status byte bit 3, ORs enabled questionable events.
module ser_status_top import ser_pkg::*; (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire ser_oper_t oper_cond_in,
   input wire ser_ques_t ques_cond_in,
   input wire ser_cmd_t cmd_in,
   output logic resp_valid_out,
   output logic [REG_W-1:0] resp_data_out,
   output logic [SB_W-1:0] status_byte_out
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   function automatic logic cmd_is(input ser_cmd_t c, input ser_op_t o);
      cmd_is = c.valid && (c.op == o);
   endfunction

   function automatic logic summary_of(input logic [REG_W-1:0] ev,
                                       input logic [REG_W-1:0] en);
      summary_of = |(ev & en);
   endfunction

   logic oper_event_rd;
   logic ques_event_rd;
   logic clear_status;
   logic preset;

   always_comb begin
      oper_event_rd = cmd_is(cmd_in, SER_OP_OPER_EVENT_Q);
      ques_event_rd = cmd_is(cmd_in, SER_OP_QUES_EVENT_Q);
      clear_status = cmd_is(cmd_in, SER_OP_CLEAR_STATUS);
      preset = cmd_is(cmd_in, SER_OP_PRESET);
   end

   // ------------------------------------------------------------
   // Live condition registers
   // ------------------------------------------------------------
   logic [REG_W-1:0] oper_live;
   logic [REG_W-1:0] ques_live;

   // Unused positions forced low; both mode error bits may stand at once
   assign oper_live = REG_W'(oper_cond_in) & OPER_USED_MASK;
   assign ques_live = REG_W'(ques_cond_in) & QUES_USED_MASK;

   // ------------------------------------------------------------
   // Event latches
   // ------------------------------------------------------------
   logic [REG_W-1:0] oper_event;
   logic [REG_W-1:0] ques_event;

   ser_event_latch #(
      .WIDTH(REG_W),
      .LATCH_MASK(OPER_LATCH_MASK)
   ) u_oper_latch (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .cond_in(oper_live),
      .clear_in(oper_event_rd || clear_status),
      .event_out(oper_event)
   );

   ser_event_latch #(
      .WIDTH(REG_W),
      .LATCH_MASK(QUES_LATCH_MASK)
   ) u_ques_latch (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n_r),
      .cond_in(ques_live),
      .clear_in(ques_event_rd || clear_status),
      .event_out(ques_event)
   );

   // ------------------------------------------------------------
   // Enable masks
   // ------------------------------------------------------------
   logic [REG_W-1:0] oper_enab_r;
   logic [REG_W-1:0] oper_enab_nxt;
   logic [REG_W-1:0] ques_enab_r;
   logic [REG_W-1:0] ques_enab_nxt;

   always_comb begin
      oper_enab_nxt = oper_enab_r;
      ques_enab_nxt = ques_enab_r;
      if (preset) begin
         oper_enab_nxt = PRESET_OPER_ENAB;
         ques_enab_nxt = PRESET_QUES_ENAB;
      end
      if (cmd_is(cmd_in, SER_OP_OPER_ENAB_W)) begin
         oper_enab_nxt = cmd_in.data;
      end
      if (cmd_is(cmd_in, SER_OP_QUES_ENAB_W)) begin
         ques_enab_nxt = cmd_in.data;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         oper_enab_r <= RESET_ENAB;
         ques_enab_r <= RESET_ENAB;
      end else begin
         oper_enab_r <= oper_enab_nxt;
         ques_enab_r <= ques_enab_nxt;
      end
   end

   // ------------------------------------------------------------
   // Status byte summaries
   // ------------------------------------------------------------
   logic oper_sum_r;
   logic oper_sum_nxt;
   logic ques_sum_r;
   logic ques_sum_nxt;
   logic [REG_W-1:0] oper_event_nxt_view;
   logic [REG_W-1:0] ques_event_nxt_view;

   // Mirror of the latch next state so the summary tracks without lag
   always_comb begin
      oper_event_nxt_view = u_oper_latch.event_nxt;
      ques_event_nxt_view = u_ques_latch.event_nxt;
      oper_sum_nxt = summary_of(oper_event_nxt_view, oper_enab_nxt);
      ques_sum_nxt = summary_of(ques_event_nxt_view, ques_enab_nxt);
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         oper_sum_r <= 1'b0;
         ques_sum_r <= 1'b0;
      end else begin
         oper_sum_r <= oper_sum_nxt;
         ques_sum_r <= ques_sum_nxt;
      end
   end

   always_comb begin
      status_byte_out = '0;
      status_byte_out[SB_OPER_BIT] = oper_sum_r;
      status_byte_out[SB_QUES_BIT] = ques_sum_r;
   end

   // ------------------------------------------------------------
   // Query answers
   // ------------------------------------------------------------
   logic resp_valid_r;
   logic resp_valid_nxt;
   logic [REG_W-1:0] resp_data_r;
   logic [REG_W-1:0] resp_data_nxt;

   always_comb begin
      resp_valid_nxt = 1'b0;
      resp_data_nxt = resp_data_r;
      if (cmd_in.valid) begin
         unique case (cmd_in.op)
            SER_OP_OPER_COND_Q: begin
               resp_valid_nxt = 1'b1;
               resp_data_nxt = oper_live;
            end
            SER_OP_OPER_ENAB_Q: begin
               resp_valid_nxt = 1'b1;
               resp_data_nxt = oper_enab_r;
            end
            SER_OP_OPER_EVENT_Q: begin
               resp_valid_nxt = 1'b1;
               resp_data_nxt = oper_event;
            end
            SER_OP_QUES_COND_Q: begin
               resp_valid_nxt = 1'b1;
               resp_data_nxt = ques_live;
            end
            SER_OP_QUES_ENAB_Q: begin
               resp_valid_nxt = 1'b1;
               resp_data_nxt = ques_enab_r;
            end
            SER_OP_QUES_EVENT_Q: begin
               resp_valid_nxt = 1'b1;
               resp_data_nxt = ques_event;
            end
            SER_OP_OPER_ENAB_W, SER_OP_QUES_ENAB_W,
            SER_OP_PRESET, SER_OP_CLEAR_STATUS: begin
               resp_valid_nxt = 1'b0;
            end
            default: begin
               resp_valid_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         resp_valid_r <= 1'b0;
         resp_data_r <= REG_ZERO;
      end else begin
         resp_valid_r <= resp_valid_nxt;
         resp_data_r <= resp_data_nxt;
      end
   end

   assign resp_valid_out = resp_valid_r;
   assign resp_data_out = resp_data_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_oper_cond_live: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      cmd_is(cmd_in, SER_OP_OPER_COND_Q)
      |=> resp_valid_out && (resp_data_out == $past(REG_W'(oper_cond_in) & OPER_USED_MASK)))
      else $error("operation condition answer wrong");

   a_oper_unused_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      (oper_event & ~OPER_USED_MASK) == REG_ZERO)
      else $error("unused operation bit latched");

   a_oper_summary_or: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      status_byte_out[SB_OPER_BIT] == (|(oper_event & oper_enab_r)))
      else $error("operation summary mismatch");

   a_oper_enab_readback: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      cmd_is(cmd_in, SER_OP_OPER_ENAB_W) ##1 cmd_is(cmd_in, SER_OP_OPER_ENAB_Q)
      |=> resp_valid_out && (resp_data_out == $past(cmd_in.data, 2)))
      else $error("operation enable readback wrong");

   a_oper_read_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      oper_event_rd && (oper_live == REG_ZERO) ##1 (oper_live == REG_ZERO)
      |-> (oper_event == REG_ZERO) && (resp_data_out == $past(oper_event)))
      else $error("operation event read did not clear");

   a_preset_masks: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      preset && !cmd_is(cmd_in, SER_OP_OPER_ENAB_W) && !cmd_is(cmd_in, SER_OP_QUES_ENAB_W)
      |=> (oper_enab_r == PRESET_OPER_ENAB) && (ques_enab_r == PRESET_QUES_ENAB)
          ##1 ((oper_enab_r == PRESET_OPER_ENAB) || $past(cmd_in.valid)))
      else $error("preset masks wrong");

   a_ques_latch_only: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      (ques_event & ~QUES_LATCH_MASK) == REG_ZERO)
      else $error("questionable bit outside latch set");

   a_ques_mode_free: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      $rose(ques_live[QUES_CURRENT_MODE_BIT]) || $rose(ques_live[QUES_VOLTAGE_MODE_BIT])
      |=> !ques_event[QUES_CURRENT_MODE_BIT] && !ques_event[QUES_VOLTAGE_MODE_BIT])
      else $error("mode error bit latched");

   a_ques_read_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      ques_event_rd
      |=> ((ques_event & ~$past(ques_live)) == REG_ZERO) && resp_valid_out)
      else $error("questionable event read did not clear");

   a_ques_cond_live: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      cmd_is(cmd_in, SER_OP_QUES_COND_Q)
      |=> resp_data_out == $past(REG_W'(ques_cond_in) & QUES_USED_MASK))
      else $error("questionable condition answer wrong");

   a_ques_summary_or: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      status_byte_out[SB_QUES_BIT] == (|(ques_event & ques_enab_r)))
      else $error("questionable summary mismatch");

   a_event_rise_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      $rose(oper_live[OPER_CONST_CURRENT_BIT])
      |=> oper_event[OPER_CONST_CURRENT_BIT]
          ##1 (oper_event[OPER_CONST_CURRENT_BIT] || $past(oper_event_rd || clear_status)))
      else $error("constant current rise not latched");

   a_resp_only_query: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      !(cmd_in.valid && (cmd_in.op inside {SER_OP_OPER_COND_Q, SER_OP_OPER_ENAB_Q,
         SER_OP_OPER_EVENT_Q, SER_OP_QUES_COND_Q, SER_OP_QUES_ENAB_Q, SER_OP_QUES_EVENT_Q}))
      |=> !resp_valid_out)
      else $error("answer without a query");

   a_oper_enab_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      cmd_is(cmd_in, SER_OP_OPER_ENAB_W) |=> oper_enab_r == $past(cmd_in.data))
      else $error("operation enable write lost");

   a_oper_enab_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      !cmd_is(cmd_in, SER_OP_OPER_ENAB_W) && !preset
      |=> oper_enab_r == $past(oper_enab_r))
      else $error("operation enable changed without write");

   a_ques_enab_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      cmd_is(cmd_in, SER_OP_QUES_ENAB_W) |=> ques_enab_r == $past(cmd_in.data))
      else $error("questionable enable write lost");

   a_oper_event_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      oper_event_rd |=> resp_valid_out && (resp_data_out == $past(oper_event)))
      else $error("operation event answer wrong");

   a_ques_event_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      ques_event_rd |=> resp_valid_out && (resp_data_out == $past(ques_event)))
      else $error("questionable event answer wrong");

   a_ques_mode_pair: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      (ques_cond_in.current_mode_error && ques_cond_in.voltage_mode_error)
      |-> (ques_live[QUES_CURRENT_MODE_BIT] && ques_live[QUES_VOLTAGE_MODE_BIT]))
      else $error("settling pair not reported");

   a_clear_drops_events: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      clear_status |=> ((oper_event & ~$past(oper_live)) == REG_ZERO)
         && ((ques_event & ~$past(ques_live)) == REG_ZERO))
      else $error("clear status left events");

   a_oper_event_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      !oper_event_rd && !clear_status
      |=> ((oper_event & $past(oper_event)) == $past(oper_event)))
      else $error("operation event dropped before read");

   a_ques_event_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r)
      !ques_event_rd && !clear_status
      |=> ((ques_event & $past(ques_event)) == $past(ques_event)))
      else $error("questionable event dropped before read");

endmodule
`default_nettype wire

/* ser_pkg.sv */
// Constants, layouts and command codes for status event reporting
package ser_pkg;

   // ------------------------------------------------------------
   // Register widths and status byte layout
   // ------------------------------------------------------------
   localparam int REG_W = 16;
   localparam int SB_W = 8;
   localparam int SB_OPER_BIT = 7;
   localparam int SB_QUES_BIT = 3;

   // ------------------------------------------------------------
   // Operation group bit positions
   // ------------------------------------------------------------
   localparam int OPER_LIST_RUNNING_BIT = 14;
   localparam int OPER_LIST_COMPLETE_BIT = 12;
   localparam int OPER_SAMPLE_COMPLETE_BIT = 11;
   localparam int OPER_CONST_CURRENT_BIT = 10;
   localparam int OPER_TRANSIENT_COMPLETE_BIT = 9;
   localparam int OPER_CONST_VOLTAGE_BIT = 8;
   localparam int OPER_TRANSIENT_ARMED_BIT = 6;
   localparam int OPER_WAITING_TRIGGER_BIT = 5;

   // ------------------------------------------------------------
   // Questionable group bit positions
   // ------------------------------------------------------------
   localparam int QUES_ABSORBING_BIT = 14;
   localparam int QUES_CURRENT_ERROR_BIT = 13;
   localparam int QUES_VOLTAGE_ERROR_BIT = 12;
   localparam int QUES_SLAVE_ERROR_BIT = 6;
   localparam int QUES_THERMAL_ERROR_BIT = 3;
   localparam int QUES_CURRENT_MODE_BIT = 1;
   localparam int QUES_VOLTAGE_MODE_BIT = 0;

   // ------------------------------------------------------------
   // Masks and preset / reset values
   // ------------------------------------------------------------
   localparam logic [REG_W-1:0] OPER_USED_MASK = 16'h5f60;
   localparam logic [REG_W-1:0] OPER_LATCH_MASK = 16'h5f60;
   localparam logic [REG_W-1:0] QUES_USED_MASK = 16'h704b;
   localparam logic [REG_W-1:0] QUES_LATCH_MASK = 16'h3000;
   localparam logic [REG_W-1:0] PRESET_OPER_ENAB = 16'h2001;
   localparam logic [REG_W-1:0] PRESET_QUES_ENAB = 16'h00ff;
   localparam logic [REG_W-1:0] RESET_ENAB = 16'h0000;
   localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic unused_bit15;
      logic list_running;
      logic unused_bit13;
      logic list_complete;
      logic sample_complete;
      logic constant_current_state;
      logic transient_complete;
      logic constant_voltage_state;
      logic unused_bit7;
      logic transient_armed;
      logic waiting_for_trigger;
      logic [4:0] unused_bits_4_0;
   } ser_oper_t;

   typedef struct packed {
      logic unused_bit15;
      logic absorbing_load_energy;
      logic current_error;
      logic voltage_error;
      logic [4:0] unused_bits_11_7;
      logic slave_error;
      logic [1:0] unused_bits_5_4;
      logic thermal_error;
      logic unused_bit2;
      logic current_mode_error;
      logic voltage_mode_error;
   } ser_ques_t;

   typedef enum logic [3:0] {
      SER_OP_OPER_COND_Q,
      SER_OP_OPER_ENAB_W,
      SER_OP_OPER_ENAB_Q,
      SER_OP_OPER_EVENT_Q,
      SER_OP_PRESET,
      SER_OP_QUES_COND_Q,
      SER_OP_QUES_ENAB_W,
      SER_OP_QUES_ENAB_Q,
      SER_OP_QUES_EVENT_Q,
      SER_OP_CLEAR_STATUS
   } ser_op_t;

   typedef struct packed {
      logic valid;
      ser_op_t op;
      logic [REG_W-1:0] data;
   } ser_cmd_t;

endpackage

/* ser_event_latch.sv */
// One event register: latches rising condition bits, cleared on demand
`timescale 1ns/1ps
`default_nettype none
module ser_event_latch import ser_pkg::*; #(
   parameter int WIDTH = REG_W,
   parameter logic [REG_W-1:0] LATCH_MASK = OPER_LATCH_MASK
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] cond_in,
   input wire logic clear_in,
   output logic [WIDTH-1:0] event_out
);

   logic [WIDTH-1:0] event_r;
   logic [WIDTH-1:0] event_nxt;
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] rise;

   // ------------------------------------------------------------
   // Next state: new rises win over a clear in the same cycle
   // ------------------------------------------------------------
   always_comb begin
      rise = cond_in & ~prev_r & LATCH_MASK[WIDTH-1:0];
      event_nxt = (clear_in ? '0 : event_r) | rise;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         event_r <= '0;
         prev_r <= '0;
      end else begin
         event_r <= event_nxt;
         prev_r <= cond_in;
      end
   end

   assign event_out = event_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_rise_sets_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (|(cond_in & ~prev_r & LATCH_MASK[WIDTH-1:0]))
      |=> ((event_r & $past(cond_in & ~prev_r & LATCH_MASK[WIDTH-1:0]))
           == $past(cond_in & ~prev_r & LATCH_MASK[WIDTH-1:0])))
      else $error("rising condition not latched");

   a_event_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !clear_in |=> ((event_r & $past(event_r)) == $past(event_r)))
      else $error("latched event lost without clear");

endmodule
`default_nettype wire

/* ser_host_model.sv */
// Host model: issues status commands and collects the answers
`timescale 1ns/1ps
`default_nettype none
module ser_host_model import ser_pkg::*; (
   input wire logic clk_in,
   input wire logic resp_valid_in,
   input wire logic [REG_W-1:0] resp_data_in,
   output var ser_cmd_t cmd_out
);
   initial begin
      cmd_out = '0;
   end

   // -------------------------------------------------
   // One command, answer seen next cycle and one later
   // -------------------------------------------------
   task automatic issue(input ser_op_t op, input logic [REG_W-1:0] d,
         output logic v, output logic v2, output logic [REG_W-1:0] r);
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b1, op: op, data: d};
      @(posedge clk_in);
      // Idle word carries inverted data so stale values never match
      cmd_out <= '{valid: 1'b0, op: op, data: ~d};
      #1;
      v = resp_valid_in;
      r = resp_data_in;
      @(posedge clk_in);
      #1;
      v2 = resp_valid_in;
   endtask

   // -------------------------------------------------
   // Two commands back to back, answer to the second
   // -------------------------------------------------
   task automatic issue_pair(input ser_op_t op1, input logic [REG_W-1:0] d1,
         input ser_op_t op2, output logic [REG_W-1:0] r);
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b1, op: op1, data: d1};
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b1, op: op2, data: ~d1};
      @(posedge clk_in);
      cmd_out <= '{valid: 1'b0, op: op2, data: d1};
      #1;
      r = resp_data_in;
   endtask
endmodule
`default_nettype wire

/* tb_ser_status_top.sv */
// Self-checking bench for status event reporting
`timescale 1ns/1ps
`default_nettype none
module tb_ser_status_top import ser_pkg::*;;
   typedef struct packed {
      ser_op_t op;
      logic [REG_W-1:0] d;
      logic [REG_W-1:0] oc;
      logic [REG_W-1:0] qc;
      logic want;
      logic [REG_W-1:0] exp;
   } ser_row_t;
   logic clk_sys_in;
   logic arst_n_in;
   ser_oper_t oper_cond;
   ser_ques_t ques_cond;
   ser_cmd_t cmd;
   logic resp_valid;
   logic [REG_W-1:0] resp_data;
   logic [SB_W-1:0] status_byte;
   logic [REG_W-1:0] pair_data;
   int n_fail;
   int checks;
   ser_row_t rows [14];

   ser_status_top uut (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .oper_cond_in(oper_cond),
      .ques_cond_in(ques_cond),
      .cmd_in(cmd),
      .resp_valid_out(resp_valid),
      .resp_data_out(resp_data),
      .status_byte_out(status_byte)
   );

   ser_host_model host (
      .clk_in(clk_sys_in),
      .resp_valid_in(resp_valid),
      .resp_data_in(resp_data),
      .cmd_out(cmd)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp,
         input string m);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic run(input ser_op_t op, input logic [REG_W-1:0] d, input logic want,
         input logic [REG_W-1:0] exp, input string m);
      logic v;
      logic v2;
      logic [REG_W-1:0] r;
      host.issue(op, d, v, v2, r);
      chk({15'h0000, v}, {15'h0000, want}, m);
      chk({15'h0000, v2}, 16'h0000, m);
      if (want) begin
         chk(r, exp, m);
      end
   endtask

   // Conditions change at an edge; events and summary settle one edge on, checked two edges on
   task automatic set_cond(input logic [REG_W-1:0] o, input logic [REG_W-1:0] q);
      @(posedge clk_sys_in);
      oper_cond <= o;
      ques_cond <= q;
      repeat (2) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk_sys_in);
      arst_n_in <= 1'b0;
      oper_cond <= '0;
      ques_cond <= '0;
      #1;
      chk({8'h00, status_byte}, 16'h0000, "status in reset");
      repeat (20) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      complete_run();
   end

   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      n_fail = 0;
      checks = 0;
      arst_n_in = 1'b0;
      oper_cond = '0;
      ques_cond = '0;
      rows = '{
         '{SER_OP_OPER_COND_Q, 16'h0000, 16'h0100, 16'h0000, 1'b1, 16'h0100},
         '{SER_OP_OPER_COND_Q, 16'h0000, 16'hffff, 16'h0000, 1'b1, 16'h5f60},
         '{SER_OP_QUES_COND_Q, 16'h0000, 16'hffff, 16'hffff, 1'b1, 16'h704b},
         '{SER_OP_QUES_COND_Q, 16'h0000, 16'hffff, 16'h0003, 1'b1, 16'h0003},
         '{SER_OP_OPER_ENAB_W, 16'h0500, 16'hffff, 16'h0003, 1'b0, 16'h0000},
         '{SER_OP_OPER_ENAB_Q, 16'h0000, 16'hffff, 16'h0003, 1'b1, 16'h0500},
         '{SER_OP_QUES_ENAB_W, 16'h3000, 16'hffff, 16'h0003, 1'b0, 16'h0000},
         '{SER_OP_QUES_ENAB_Q, 16'h0000, 16'hffff, 16'h0003, 1'b1, 16'h3000},
         '{SER_OP_PRESET, 16'h0000, 16'hffff, 16'h0003, 1'b0, 16'h0000},
         '{SER_OP_OPER_ENAB_Q, 16'h0000, 16'hffff, 16'h0003, 1'b1, 16'h2001},
         '{SER_OP_QUES_ENAB_Q, 16'h0000, 16'hffff, 16'h0003, 1'b1, 16'h00ff},
         '{SER_OP_CLEAR_STATUS, 16'h0000, 16'hffff, 16'h0003, 1'b0, 16'h0000},
         '{SER_OP_OPER_EVENT_Q, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h0000},
         '{SER_OP_QUES_EVENT_Q, 16'h0000, 16'h0000, 16'h0000, 1'b1, 16'h0000}
      };
      do_reset();
      run(SER_OP_OPER_ENAB_Q, 16'h0000, 1'b1, 16'h0000, "enable after reset");
      run(SER_OP_OPER_EVENT_Q, 16'h0000, 1'b1, 16'h0000, "events after reset");
      $display("reset test done");
      foreach (rows[i]) begin
         set_cond(rows[i].oc, rows[i].qc);
         run(rows[i].op, rows[i].d, rows[i].want, rows[i].exp, "table row");
      end
      $display("table test done");
      // Write and query of the mask in consecutive cycles
      host.issue_pair(SER_OP_OPER_ENAB_W, 16'h0a00, SER_OP_OPER_ENAB_Q, pair_data);
      chk(pair_data, 16'h0a00, "back to back mask");
      // Operation events latch on rise, summary follows mask, read clears
      run(SER_OP_OPER_ENAB_W, 16'h0400, 1'b0, 16'h0000, "oper mask write");
      set_cond(16'h0500, 16'h0000);
      chk({8'h00, status_byte}, 16'h0080, "oper summary set");
      run(SER_OP_OPER_EVENT_Q, 16'h0000, 1'b1, 16'h0500, "oper events");
      chk({8'h00, status_byte}, 16'h0000, "oper summary clear");
      run(SER_OP_OPER_EVENT_Q, 16'h0000, 1'b1, 16'h0000, "oper reread");
      set_cond(16'h0000, 16'h0000);
      run(SER_OP_OPER_EVENT_Q, 16'h0000, 1'b1, 16'h0000, "oper fall");
      $display("operation event test done");
      // Questionable group latches only the two error bits
      run(SER_OP_QUES_ENAB_W, 16'hffff, 1'b0, 16'h0000, "ques mask write");
      set_cond(16'h0000, 16'hffff);
      chk({8'h00, status_byte}, 16'h0008, "ques summary set");
      run(SER_OP_QUES_EVENT_Q, 16'h0000, 1'b1, 16'h3000, "ques events");
      chk({8'h00, status_byte}, 16'h0000, "ques summary clear");
      run(SER_OP_QUES_EVENT_Q, 16'h0000, 1'b1, 16'h0000, "ques reread");
      $display("questionable event test done");
      // Clear status drops a latched event
      set_cond(16'h0020, 16'h0000);
      run(SER_OP_CLEAR_STATUS, 16'h0000, 1'b0, 16'h0000, "clear status");
      run(SER_OP_OPER_EVENT_Q, 16'h0000, 1'b1, 16'h0000, "after clear");
      $display("clear status test done");
      // Reset in mid-run with a summary pending
      set_cond(16'h0400, 16'h0000);
      chk({8'h00, status_byte}, 16'h0080, "summary before reset");
      do_reset();
      run(SER_OP_QUES_ENAB_Q, 16'h0000, 1'b1, 16'h0000, "mask after reset");
      run(SER_OP_QUES_EVENT_Q, 16'h0000, 1'b1, 16'h0000, "ques after reset");
      $display("second reset test done");
      complete_run();
   end
endmodule
`default_nettype wire
